//--- p4mux_pkg.sv
// Register map, field positions and decode helpers for the port 4 pin mux
package p4mux_pkg;

	localparam int unsigned P4MUX_ADDR_W = 8;

	localparam logic [7:0] ADDR_LATCH  = 8'h00;
	localparam logic [7:0] ADDR_DIR    = 8'h04;
	localparam logic [7:0] ADDR_ROUTE  = 8'h08;
	localparam logic [7:0] ADDR_TIMER  = 8'h0c;
	localparam logic [7:0] ADDR_SERIAL = 8'h10;
	localparam logic [7:0] ADDR_PINS   = 8'h14;
	localparam logic [7:0] ADDR_FUNC   = 8'h18;

	localparam logic [7:0]  LATCH_RST  = 8'h00;
	localparam logic [7:0]  DIR_RST    = 8'h00;
	localparam logic [31:0] ROUTE_RST  = 32'h0000_0000;
	localparam logic [31:0] TIMER_RST  = 32'h0000_0000;
	localparam logic [31:0] SERIAL_RST = 32'h0000_0000;

	// Writable bits; the rest read back as zero
	localparam logic [31:0] ROUTE_MASK  = 32'h0000_01ff;
	localparam logic [31:0] TIMER_MASK  = 32'h01ff_01ff;
	localparam logic [31:0] SERIAL_MASK = 32'h0000_1f07;

	// Route register fields
	localparam int unsigned RT_PWM_A   = 0;
	localparam int unsigned RT_PWM_B   = 1;
	localparam int unsigned RT_S1_CLK  = 2;
	localparam int unsigned RT_I2C_EN  = 3;
	localparam int unsigned RT_I2C_RA  = 4;
	localparam int unsigned RT_I2C_RB  = 5;
	localparam int unsigned RT_IRQ7_PS = 6;
	localparam int unsigned RT_IRQ7_EN = 7;
	localparam int unsigned RT_T0_CLK  = 8;

	// Timer register fields (low bit of each field)
	localparam int unsigned TM_T0_CCLR = 0;
	localparam int unsigned TM_T0_OS   = 2;
	localparam int unsigned TM_T0_CKS  = 6;
	localparam int unsigned TM_T1_CCLR = 16;
	localparam int unsigned TM_T1_OS   = 18;
	localparam int unsigned TM_T1_CKS  = 22;

	// Serial register fields
	localparam int unsigned SR_S1_CKE_LO = 0;
	localparam int unsigned SR_S1_CKE_HI = 1;
	localparam int unsigned SR_S1_SYNC   = 2;
	localparam int unsigned SR_S2_CKE_LO = 8;
	localparam int unsigned SR_S2_CKE_HI = 9;
	localparam int unsigned SR_S2_SYNC   = 10;
	localparam int unsigned SR_S2_RE     = 11;
	localparam int unsigned SR_S2_TE     = 12;

	localparam logic [1:0] CCLR_PIN_RESET = 2'h3;
	localparam logic [2:0] CKS_EXT_FIRST  = 3'h5;

	// Clock-select codes from CKS_EXT_FIRST upward pick an external clock
	function automatic logic is_ext_clock(input logic [2:0] cks);
		is_ext_clock = (cks >= CKS_EXT_FIRST);
	endfunction

endpackage

//--- p4mux_pin_drv.sv
// Registered output driver for one port pin
`timescale 1ns/1ps
module p4mux_pin_drv
	import p4mux_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic gp_dir,
	input  wire logic gp_val,
	input  wire logic fn_in,
	input  wire logic fn_out,
	input  wire logic fn_od,
	input  wire logic fn_val,
	output logic      pin_out,
	output logic      pin_oe
);

	logic nxt_out;
	logic nxt_oe;
	logic out_ff;
	logic oe_ff;

	// Peripheral input wins, then peripheral output, then general I/O
	always_comb
	begin
		nxt_out = gp_val;
		nxt_oe  = gp_dir;
		if (fn_in)
		begin
			nxt_out = 1'b0;
			nxt_oe  = 1'b0;
		end
		else if (fn_out && fn_od)
		begin
			// Open drain: only ever pulls low, bus resistor gives the high
			nxt_out = 1'b0;
			nxt_oe  = ~fn_val;
		end
		else if (fn_out)
		begin
			nxt_out = fn_val;
			nxt_oe  = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			out_ff <= 1'b0;
			oe_ff  <= 1'b0;
		end
		else
		begin
			out_ff <= nxt_out;
			oe_ff  <= nxt_oe;
		end
	end

	assign pin_out = out_ff;
	assign pin_oe  = oe_ff;

endmodule

//--- p4mux_in_route.sv
// Gated, registered path from a pin to one peripheral input
`timescale 1ns/1ps
module p4mux_in_route
	import p4mux_pkg::*;
#(
	parameter logic IDLE = 1'b0
)
(
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic pin_level,
	input  wire logic route_en,
	output logic      periph_in
);

	logic in_ff;

	// Pin is watched whatever it drives, so a peripheral can see its own output
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			in_ff <= IDLE;
		else
			in_ff <= route_en ? pin_level : IDLE;
	end

	assign periph_in = in_ff;

endmodule

//--- p4mux_top.sv
// Port 4 general I/O with per-pin peripheral function selection, APB registers
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Eight-bit read/write output latch feeds general output pins, resets to zero.
// - Latch read gives latch bit where direction is one, else pin level.
// - PWM B enable puts PWM channel 1 on pin 7, else general I/O.
// - PWM A enable puts PWM channel 0 on pin 6, else general I/O.
// - Pin 5 is general I/O and feeds timer 1 reset when clear-select is 11.
// - Any timer 1 output-select bit puts its compare output on pin 4.
// - Pin 3 serial 1 clock in or out when routed, by clock enables and sync.
// - Pin 3 feeds timer 1 external clock when its clock select is external.
// - With I2C route on, pin 2 is open-drain I2C data line.
// - Without I2C, pin 2 is serial 2 clock in or out, else general I/O.
// - Pin 2 as general output or serial 2 clock output is push-pull.
// - Pin 2 feeds interrupt 7 when its pin-select and enable are both set.
// - Pin 2 feeds timer 0 reset when its clear-select is 11.
// - Pin 1: serial 2 receive first, then timer 0 compare out, else general.
// - Serial 2 transmit enable puts transmit data on pin 0, else general I/O.
// - Pin 0 feeds timer 0 clock when route bit is zero and select external.
// - Write-only direction bits, reset zero, make general pins outputs when set.
module p4mux_top
	import p4mux_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    srst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [P4MUX_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [7:0]              pin_in,
	output logic      [7:0]              pin_out,
	output logic      [7:0]              pin_oe,
	input  wire logic                    pwm_ch1_out,
	input  wire logic                    pwm_ch0_out,
	input  wire logic                    timer1_compare_out,
	input  wire logic                    timer0_compare_out,
	input  wire logic                    serial1_clock_out,
	input  wire logic                    serial2_clock_out,
	input  wire logic                    serial2_transmit_out,
	input  wire logic                    i2c_data_out,
	output logic                         timer1_reset_in,
	output logic                         timer0_reset_in,
	output logic                         timer1_ext_clock_in,
	output logic                         timer0_ext_clock_in,
	output logic                         serial1_clock_in,
	output logic                         serial2_clock_in,
	output logic                         serial2_receive_in,
	output logic                         i2c_data_in,
	output logic                         ext_interrupt7_in_n
);

	logic [7:0]  latch_ff;
	logic [7:0]  dir_ff;
	logic [31:0] route_ff;
	logic [31:0] timer_ff;
	logic [31:0] serial_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic [7:0]  port_read;
	logic        wr_acc;
	logic        rd_setup;
	logic [7:0]  fn_in;
	logic [7:0]  fn_out;
	logic [7:0]  fn_od;
	logic [7:0]  fn_val;
	logic        i2c_route_active;
	logic [1:0]  t0_cclr;
	logic [3:0]  t0_os;
	logic [2:0]  t0_cks;
	logic [1:0]  t1_cclr;
	logic [3:0]  t1_os;
	logic [2:0]  t1_cks;
	logic        s1_route;
	logic        s1_cke_hi;
	logic        s1_clk_out;
	logic        s2_cke_hi;
	logic        s2_clk_out;
	logic        s2_re;
	logic        s2_te;

	function automatic logic addr_hit(input logic [P4MUX_ADDR_W-1:0] a);
		addr_hit = (a == ADDR_LATCH) || (a == ADDR_DIR) || (a == ADDR_ROUTE)
			|| (a == ADDR_TIMER) || (a == ADDR_SERIAL) || (a == ADDR_PINS)
			|| (a == ADDR_FUNC);
	endfunction

	// Zero-wait slave: read data is captured in the setup cycle
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addr_hit(paddr);
	assign prdata   = prdata_ff;
	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			latch_ff <= LATCH_RST;
		else if (wr_acc && paddr == ADDR_LATCH)
			latch_ff <= pwdata[7:0];
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			dir_ff <= DIR_RST;
		else if (wr_acc && paddr == ADDR_DIR)
			dir_ff <= pwdata[7:0];
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			route_ff <= ROUTE_RST;
		else if (wr_acc && paddr == ADDR_ROUTE)
			route_ff <= pwdata & ROUTE_MASK;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			timer_ff <= TIMER_RST;
		else if (wr_acc && paddr == ADDR_TIMER)
			timer_ff <= pwdata & TIMER_MASK;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			serial_ff <= SERIAL_RST;
		else if (wr_acc && paddr == ADDR_SERIAL)
			serial_ff <= pwdata & SERIAL_MASK;
	end

	// Output pins read back their latch, input pins their level
	assign port_read = (latch_ff & dir_ff) | (pin_in & ~dir_ff);

	always_comb
	begin
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			ADDR_LATCH:  nxt_prdata = {24'h00_0000, port_read};
			ADDR_ROUTE:  nxt_prdata = route_ff;
			ADDR_TIMER:  nxt_prdata = timer_ff;
			ADDR_SERIAL: nxt_prdata = serial_ff;
			ADDR_PINS:   nxt_prdata = {24'h00_0000, pin_in};
			ADDR_FUNC:   nxt_prdata = {8'h00, fn_od, fn_in, fn_out};
			default:     nxt_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			prdata_ff <= 32'h0000_0000;
		else if (rd_setup)
			prdata_ff <= nxt_prdata;
	end

	// Field decode
	assign t0_cclr    = timer_ff[TM_T0_CCLR +: 2];
	assign t0_os      = timer_ff[TM_T0_OS +: 4];
	assign t0_cks     = timer_ff[TM_T0_CKS +: 3];
	assign t1_cclr    = timer_ff[TM_T1_CCLR +: 2];
	assign t1_os      = timer_ff[TM_T1_OS +: 4];
	assign t1_cks     = timer_ff[TM_T1_CKS +: 3];
	assign s1_route   = route_ff[RT_S1_CLK];
	assign s1_cke_hi  = serial_ff[SR_S1_CKE_HI];
	assign s1_clk_out = serial_ff[SR_S1_SYNC] || serial_ff[SR_S1_CKE_LO];
	assign s2_cke_hi  = serial_ff[SR_S2_CKE_HI];
	assign s2_clk_out = serial_ff[SR_S2_SYNC] || serial_ff[SR_S2_CKE_LO];
	assign s2_re      = serial_ff[SR_S2_RE];
	assign s2_te      = serial_ff[SR_S2_TE];
	// Software is trusted to clear the serial 2 clock bits too
	assign i2c_route_active = route_ff[RT_I2C_EN] && !route_ff[RT_I2C_RA]
		&& !route_ff[RT_I2C_RB];

	always_comb
	begin
		fn_in  = 8'h00;
		fn_out = 8'h00;
		fn_od  = 8'h00;
		fn_val = 8'h00;
		fn_out[7] = route_ff[RT_PWM_B];
		fn_val[7] = pwm_ch1_out;
		fn_out[6] = route_ff[RT_PWM_A];
		fn_val[6] = pwm_ch0_out;
		fn_out[4] = |t1_os;
		fn_val[4] = timer1_compare_out;
		if (s1_route)
		begin
			fn_in[3]  = s1_cke_hi;
			fn_out[3] = !s1_cke_hi && s1_clk_out;
		end
		fn_val[3] = serial1_clock_out;
		if (i2c_route_active)
		begin
			fn_out[2] = 1'b1;
			fn_od[2]  = 1'b1;
			fn_val[2] = i2c_data_out;
		end
		else
		begin
			fn_in[2]  = s2_cke_hi;
			fn_out[2] = !s2_cke_hi && s2_clk_out;
			fn_val[2] = serial2_clock_out;
		end
		// Receive owns the pin even if a compare output is also selected
		fn_in[1]  = s2_re;
		fn_out[1] = !s2_re && (|t0_os);
		fn_val[1] = timer0_compare_out;
		fn_out[0] = s2_te;
		fn_val[0] = serial2_transmit_out;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pin
			p4mux_pin_drv u_drv (
				.ref_clk (ref_clk),
				.srst    (srst),
				.gp_dir  (dir_ff[gi]),
				.gp_val  (latch_ff[gi]),
				.fn_in   (fn_in[gi]),
				.fn_out  (fn_out[gi]),
				.fn_od   (fn_od[gi]),
				.fn_val  (fn_val[gi]),
				.pin_out (pin_out[gi]),
				.pin_oe  (pin_oe[gi])
			);
		end
	endgenerate

	p4mux_in_route #(.IDLE(1'b0)) u_t1_rst (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[5]),
		.route_en  (t1_cclr == CCLR_PIN_RESET),
		.periph_in (timer1_reset_in)
	);
	p4mux_in_route #(.IDLE(1'b0)) u_t1_clk (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[3]),
		.route_en  (is_ext_clock(t1_cks)),
		.periph_in (timer1_ext_clock_in)
	);
	p4mux_in_route #(.IDLE(1'b0)) u_s1_clk (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[3]),
		.route_en  (fn_in[3]),
		.periph_in (serial1_clock_in)
	);
	p4mux_in_route #(.IDLE(1'b1)) u_i2c (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[2]),
		.route_en  (i2c_route_active),
		.periph_in (i2c_data_in)
	);
	p4mux_in_route #(.IDLE(1'b0)) u_s2_clk (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[2]),
		.route_en  (fn_in[2]),
		.periph_in (serial2_clock_in)
	);
	// Interrupt input is active low, so it idles high while unrouted
	p4mux_in_route #(.IDLE(1'b1)) u_irq7 (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[2]),
		.route_en  (route_ff[RT_IRQ7_PS] && route_ff[RT_IRQ7_EN]),
		.periph_in (ext_interrupt7_in_n)
	);
	p4mux_in_route #(.IDLE(1'b0)) u_t0_rst (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[2]),
		.route_en  (t0_cclr == CCLR_PIN_RESET),
		.periph_in (timer0_reset_in)
	);
	// Receive line idles at mark level while the receiver is off
	p4mux_in_route #(.IDLE(1'b1)) u_rxd (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[1]),
		.route_en  (s2_re),
		.periph_in (serial2_receive_in)
	);
	p4mux_in_route #(.IDLE(1'b0)) u_t0_clk (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.pin_level (pin_in[0]),
		.route_en  (!route_ff[RT_T0_CLK] && is_ext_clock(t0_cks)),
		.periph_in (timer0_ext_clock_in)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_latch_write_store: assert property (
		wr_acc && paddr == ADDR_LATCH |=> latch_ff == $past(pwdata[7:0]))
		else $error("latch did not take written value");
	a_read_mix_dir: assert property (
		rd_setup && paddr == ADDR_LATCH |=>
		prdata[7:0] == (($past(latch_ff) & $past(dir_ff)) | ($past(pin_in) & ~$past(dir_ff))))
		else $error("latch read does not mix latch and pin by direction");
	a_pwm_b_drive: assert property (
		route_ff[RT_PWM_B] |=> pin_oe[7] && pin_out[7] == $past(pwm_ch1_out))
		else $error("pwm channel 1 not on pin 7");
	a_pwm_a_drive: assert property (
		route_ff[RT_PWM_A] |=> pin_oe[6] && pin_out[6] == $past(pwm_ch0_out))
		else $error("pwm channel 0 not on pin 6");
	a_t1_reset_feed: assert property (
		t1_cclr == CCLR_PIN_RESET |=> timer1_reset_in == $past(pin_in[5]))
		else $error("timer 1 reset not fed from pin 5");
	a_t1_compare_drive: assert property (
		(|t1_os) |=> pin_oe[4] && pin_out[4] == $past(timer1_compare_out))
		else $error("timer 1 compare not on pin 4");
	a_sck1_input_mode: assert property (
		s1_route && s1_cke_hi |=> !pin_oe[3] && serial1_clock_in == $past(pin_in[3]))
		else $error("pin 3 not serial 1 clock input");
	a_t1_ext_clock: assert property (
		is_ext_clock(t1_cks) |=> timer1_ext_clock_in == $past(pin_in[3]))
		else $error("timer 1 clock not fed from pin 3");
	a_sda_open_drain: assert property (
		i2c_route_active |=> !pin_out[2] && pin_oe[2] == !$past(i2c_data_out))
		else $error("i2c data not open drain on pin 2");
	a_serial2_clock_input_mode: assert property (
		!i2c_route_active && s2_cke_hi |=> !pin_oe[2] && serial2_clock_in == $past(pin_in[2]))
		else $error("pin 2 not serial 2 clock input");
	a_p42_push_pull: assert property (
		!i2c_route_active && !s2_cke_hi && s2_clk_out |=>
		pin_oe[2] && pin_out[2] == $past(serial2_clock_out))
		else $error("serial 2 clock output not push-pull");
	a_irq7_feed: assert property (
		route_ff[RT_IRQ7_PS] && route_ff[RT_IRQ7_EN] |=> ext_interrupt7_in_n == $past(pin_in[2]))
		else $error("interrupt 7 not fed from pin 2");
	a_t0_reset_feed: assert property (
		t0_cclr == CCLR_PIN_RESET |=> timer0_reset_in == $past(pin_in[2]))
		else $error("timer 0 reset not fed from pin 2");
	a_rxd_priority: assert property (
		s2_re |=> !pin_oe[1] && serial2_receive_in == $past(pin_in[1]))
		else $error("receive does not own pin 1");
	a_txd_drive: assert property (
		s2_te |=> pin_oe[0] && pin_out[0] == $past(serial2_transmit_out))
		else $error("transmit data not on pin 0");
	a_t0_ext_clock: assert property (
		!route_ff[RT_T0_CLK] && is_ext_clock(t0_cks) |=> timer0_ext_clock_in == $past(pin_in[0]))
		else $error("timer 0 clock not fed from pin 0");
	a_gp_dir_pin5: assert property (
		1'b1 |=> pin_oe[5] == $past(dir_ff[5]) && pin_out[5] == $past(latch_ff[5]))
		else $error("pin 5 general I/O does not follow direction");

	c_latch_write: cover property (wr_acc && paddr == ADDR_LATCH ##2 pin_oe[5]);
	c_i2c_low: cover property (i2c_route_active && !i2c_data_out ##1 pin_oe[2]);
	c_rx_over_cmp: cover property (s2_re && (|t0_os));
	c_mixed_read: cover property (rd_setup && paddr == ADDR_LATCH && dir_ff == 8'h0f);

endmodule

//--- p4mux_partner.sv
// Board-side model of the port 4 pins: what each pin wire carries
`timescale 1ns/1ps
module p4mux_partner (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_lvl,
	output logic      [7:0] pin_in
);
	// A driven pin shows the chip's value. An undriven pin shows the board level, so a
	// released line never keeps the last driven value.
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
		end
	end
endmodule

//--- p4mux_tb_top.sv
// Self-checking bench for the port 4 pin mux, random and directed routing cases
`timescale 1ns/1ps
module p4mux_tb_top
	import p4mux_pkg::*;
;
	logic        ref_clk = 0;
	logic        srst    = 1;
	logic        psel    = 0;
	logic        penable = 0;
	logic        pwrite  = 0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic [7:0]  ext_lvl = 8'h5a;
	logic [7:0]  per     = 8'h00;
	wire  [8:0]  rin;
	int          mismatches = 0;
	int          n_tests    = 0;
	logic [31:0] rd;
	logic        err;

	always #20 ref_clk = ~ref_clk;

	p4mux_top p4mux_top_inst (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pwm_ch1_out(per[7]), .pwm_ch0_out(per[6]), .timer1_compare_out(per[5]),
		.timer0_compare_out(per[4]), .serial1_clock_out(per[3]), .serial2_clock_out(per[2]),
		.serial2_transmit_out(per[1]), .i2c_data_out(per[0]), .timer1_reset_in(rin[8]),
		.timer0_reset_in(rin[7]), .timer1_ext_clock_in(rin[6]), .timer0_ext_clock_in(rin[5]),
		.serial1_clock_in(rin[4]), .serial2_clock_in(rin[3]), .serial2_receive_in(rin[2]),
		.i2c_data_in(rin[1]), .ext_interrupt7_in_n(rin[0]));

	p4mux_partner p4mux_partner_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
		.pin_in(pin_in));

	task automatic give_verdict;
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Holds the request until pready is seen high; only the watchdog ends a stuck wait
	task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reference pin mux: general I/O first, then peripheral overrides
	function automatic void calc(input bit [31:0] r, t, s, l, d, p, e,
		output bit [7:0] o, v, lv, output bit [8:0] ri, output bit [23:0] fx);
		bit i2c;
		i2c = r[3] & !r[4] & !r[5];
		o = d[7:0];
		v = l[7:0];
		if (r[1]) begin o[7] = 1; v[7] = p[7]; end
		if (r[0]) begin o[6] = 1; v[6] = p[6]; end
		if (|t[21:18]) begin o[4] = 1; v[4] = p[5]; end
		if (r[2] && s[1]) o[3] = 0;
		else if (r[2] && (s[2] | s[0])) begin o[3] = 1; v[3] = p[3]; end
		if (i2c) begin o[2] = !p[0]; v[2] = 0; end
		else if (s[9]) o[2] = 0;
		else if (s[10] | s[8]) begin o[2] = 1; v[2] = p[2]; end
		if (s[11]) o[1] = 0;
		else if (|t[5:2]) begin o[1] = 1; v[1] = p[4]; end
		if (s[12]) begin o[0] = 1; v[0] = p[1]; end
		lv = (o & v) | (~o & e[7:0]);
		ri = {(t[17:16] == 2'h3) & lv[5], (t[1:0] == 2'h3) & lv[2], (t[24:22] >= 3'h5) & lv[3],
			!r[8] & (t[8:6] >= 3'h5) & lv[0], r[2] & s[1] & lv[3], !i2c & s[9] & lv[2],
			!s[11] | lv[1], !i2c | lv[2], !(r[6] & r[7]) | lv[2]};
		// Per-pin function map: peripheral outputs, peripheral inputs, open drain
		fx[7:0] = {r[1], r[0], 1'b0, |t[21:18], r[2] & !s[1] & (s[2] | s[0]),
			i2c | (!s[9] & (s[10] | s[8])), !s[11] & (|t[5:2]), s[12]};
		fx[15:8] = {4'h0, r[2] & s[1], !i2c & s[9], s[11], 1'b0};
		fx[23:16] = {5'h00, i2c, 2'h0};
	endfunction

	task automatic run_case(input bit [31:0] r, t, s, l, d, p, e);
		bit [7:0] o, v, lv;
		bit [8:0] ri;
		bit [23:0] fx;
		per     <= p[7:0];
		ext_lvl <= e[7:0];
		apb(1, ADDR_ROUTE, r, rd, err);
		apb(1, ADDR_TIMER, t, rd, err);
		apb(1, ADDR_SERIAL, s, rd, err);
		apb(1, ADDR_LATCH, l, rd, err);
		apb(1, ADDR_DIR, d, rd, err);
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		calc(r, t, s, l, d, p, e, o, v, lv, ri, fx);
		check("pin_oe", pin_oe, o);
		check("pin_out", pin_out & pin_oe, v & o);
		check("routed_in", rin, ri);
		apb(0, ADDR_LATCH, 0, rd, err);
		check("latch_rd", rd, {24'h0, (l[7:0] & d[7:0]) | (lv & ~d[7:0])});
		check("latch_err", err, 1'b0);
		apb(0, ADDR_PINS, 0, rd, err);
		check("pins_rd", rd, {24'h0, lv});
		apb(0, ADDR_FUNC, 0, rd, err);
		check("func_rd", rd, {8'h0, fx});
		apb(0, ADDR_DIR, 0, rd, err);
		check("dir_rd", rd, 32'h0);
		apb(0, ADDR_ROUTE, 0, rd, err);
		check("route_rd", rd, r & ROUTE_MASK);
		apb(0, ADDR_TIMER, 0, rd, err);
		check("timer_rd", rd, t & TIMER_MASK);
		apb(0, ADDR_SERIAL, 0, rd, err);
		check("serial_rd", rd, s & SERIAL_MASK);
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		give_verdict();
	end

	initial
	begin
		void'($urandom(32'h2efcd2fe));
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		check("rst_oe", pin_oe, 8'h00);
		check("rst_out", pin_out, 8'h00);
		check("rst_rin", rin, 9'h007);
		apb(0, ADDR_LATCH, 0, rd, err);
		check("rst_latch", rd, 32'h5a);
		apb(0, 8'h40, 32'hffff_ffff, rd, err);
		check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		// I2C data set up the way software must: enable on, routes and serial 2 clock off
		run_case(32'h8, 0, 0, 32'hff, 32'hff, 32'h00, 32'h04);
		run_case(32'h8, 0, 0, 32'hff, 32'hff, 32'h01, 32'h00);
		// Timer 0 compare on pin 1 with serial 2 receive held off
		run_case(0, 32'h3c, 0, 0, 0, 32'h10, 0);
		for (int k = 0; k < 150; k++)
			run_case($urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom);
		// Second reset in mid-run must clear every routing choice again
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		check("rst2_oe", pin_oe, 8'h00);
		check("rst2_out", pin_out, 8'h00);
		check("rst2_rin", rin, 9'h007);
		apb(0, ADDR_ROUTE, 0, rd, err);
		check("rst2_route", rd, ROUTE_RST);
		give_verdict();
	end
endmodule
